// file: hdl/cnm_change_det.sv
`timescale 1ns/100ps
module cnm_change_det
  import cnm_pkg::*;
#(
  parameter int N = RPT_NUM,
  parameter int W = 32
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [N-1:0][W-1:0] value,
  output logic [N-1:0] changed
);

  logic [N-1:0][W-1:0] prev_r;
  logic primed_r;

  // No change is reported before the first value has been captured
  always_comb
  begin
    for (int i = 0; i < N; i++)
      changed[i] = primed_r & (value[i] != prev_r[i]);
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prev_r <= '0;
      primed_r <= 1'b0;
    end
    else
    begin
      prev_r <= value;
      primed_r <= 1'b1;
    end
  end

endmodule

// file: hdl/cnm_network_role.sv
// Operation
// - Role register bits are individual mode flags
// - Value 0x00 means stand-alone, internal profile
// - Value 0x21 means charge master, internal profile
// - Setpoints stale one minute: back to stand-alone
// - Charge and hub remote behave alike
// - Managed remote mode sets controller-present flag
// - Controller present: no fallback, raise error 67
// - Instance master reports setpoint and timing periodically
// - Master keeps internal profile, no gathering
// - Feedback low nibble reports control source
// - Feedback bits 6, 7 flag remote sensing
// - Reports use async command, get layout
// - History records reported whenever they change
// - Change reports while hex traffic, stop after 2min
// - Report output voltage, clock, sense timeout values
`timescale 1ns/100ps
module cnm_network_role
  import cnm_pkg::*;
#(
  parameter logic [TIMER_W-1:0] SUPERVISE_CNT = TIMER_W'(SUPERVISE_CYCLES),
  parameter logic [TIMER_W-1:0] HEXIDLE_CNT = TIMER_W'(HEXIDLE_CYCLES),
  parameter logic [TIMER_W-1:0] MASTER_CNT = TIMER_W'(MASTER_PERIOD_CYCLES)
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input cnm_req_s accReq,
  output cnm_rsp_s accRsp,
  input wire logic respBusy,
  input wire logic hexFrameSeen,
  input wire logic [15:0] intSetpoint,
  input wire logic [31:0] chargeElapsed,
  input wire logic [15:0] absorbLeft,
  input wire logic [15:0] outVoltage,
  input wire logic [7:0] rtcState,
  input wire logic histTotalChanged,
  input wire logic histTodayChanged,
  output cnm_rpt_s rpt,
  input wire logic rptReady,
  output logic [7:0] netMode,
  output logic [7:0] netStatus,
  output logic standAlone,
  output logic setpointRemote,
  output logic hubDisplay,
  output logic [15:0] voltSetpoint,
  output logic [7:0] remoteDevState,
  output logic [7:0] curPercent,
  output logic [15:0] curLimit,
  output logic bmcPresent,
  output logic [7:0] bmcErrCode,
  output logic vsenseUse,
  output logic tsenseUse,
  output logic [15:0] vsenseVal,
  output logic [15:0] tsenseVal
);

  function automatic logic [RPT_IDX_W-1:0] oneHotIdx(
    input logic [RPT_NUM-1:0] oh
  );
    logic [RPT_IDX_W-1:0] idx;
    idx = '0;
    for (int i = 0; i < RPT_NUM; i++)
      if (oh[i])
        idx = RPT_IDX_W'(i);
    return idx;
  endfunction

  function automatic logic [15:0] rptIdOf(input logic [RPT_IDX_W-1:0] idx);
    logic [15:0] id;
    case (idx)
      RPT_IDX_W'(RPT_HIST_TOTAL): id = ID_HIST_TOTAL;
      RPT_IDX_W'(RPT_HIST_TODAY): id = ID_HIST_TODAY;
      RPT_IDX_W'(RPT_VOLT_SET): id = ID_VOLT_SET;
      RPT_IDX_W'(RPT_ELAPSED): id = ID_ELAPSED;
      RPT_IDX_W'(RPT_ABSORB): id = ID_ABSORB_LEFT;
      RPT_IDX_W'(RPT_OUT_VOLT): id = ID_OUT_VOLT;
      RPT_IDX_W'(RPT_RTC): id = ID_RTC_STATE;
      RPT_IDX_W'(RPT_VSENSE): id = ID_VSENSE;
      RPT_IDX_W'(RPT_TSENSE): id = ID_TSENSE;
      RPT_IDX_W'(RPT_MODE): id = ID_NET_MODE;
      RPT_IDX_W'(RPT_STATUS): id = ID_NET_STATUS;
      default: id = 16'h0000;
    endcase
    return id;
  endfunction

  // Register state
  logic [MODE_W-1:0] mode_r;
  logic [MODE_W-1:0] mode_nxt;
  logic [15:0] voltSet_r;
  logic [15:0] vsense_r;
  logic [15:0] vsense_nxt;
  logic [15:0] tsense_r;
  logic [15:0] tsense_nxt;
  logic vsUse_r;
  logic vsUse_nxt;
  logic tsUse_r;
  logic tsUse_nxt;
  logic [7:0] devState_r;
  logic [7:0] curPct_r;
  logic [15:0] curLim_r;
  logic bmcPresent_r;
  logic bmcPresent_nxt;
  logic bmcLost_r;
  logic bmcLost_nxt;
  logic hexActive_r;
  logic hexActive_nxt;
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [15:0] effSet_r;
  logic [15:0] effSet_nxt;
  cnm_rsp_s rsp_r;
  cnm_rsp_s rsp_nxt;

  // Access decode
  wire wr = accReq.valid & accReq.write;
  wire idMode = (accReq.id == ID_NET_MODE);
  wire idStatus = (accReq.id == ID_NET_STATUS);
  wire idSet = (accReq.id == ID_VOLT_SET);
  wire idVs = (accReq.id == ID_VSENSE);
  wire idTs = (accReq.id == ID_TSENSE);
  wire idElapsed = (accReq.id == ID_ELAPSED);
  wire idAbsorb = (accReq.id == ID_ABSORB_LEFT);
  wire idDev = (accReq.id == ID_DEV_STATE);
  wire idPct = (accReq.id == ID_CUR_PCT);
  wire idLim = (accReq.id == ID_CUR_LIMIT);
  wire idBmc = (accReq.id == ID_BMC_PRESENT);
  wire idOutV = (accReq.id == ID_OUT_VOLT);
  wire idRtc = (accReq.id == ID_RTC_STATE);
  wire idWritable = idMode | idSet | idVs | idTs | idDev | idPct | idLim
                    | idBmc;
  wire idReadOnly = idStatus | idElapsed | idAbsorb | idOutV | idRtc;
  wire wrMode = wr & idMode;
  wire wrSet = wr & idSet;
  wire wrVs = wr & idVs;
  wire wrTs = wr & idTs;
  wire wrDev = wr & idDev;
  wire wrPct = wr & idPct;
  wire wrLim = wr & idLim;
  wire wrBmc = wr & idBmc;

  // Role decode
  wire remCharge = mode_r[MODE_REM_CHARGE];
  wire remHub = mode_r[MODE_REM_HUB];
  wire remBmc = mode_r[MODE_REM_BMC];
  wire grpMaster = mode_r[MODE_GRP_MASTER];
  wire instMaster = mode_r[MODE_INST_MASTER];
  wire remoteCtl = remCharge | remHub | remBmc;
  wire voltRemote = remCharge | remHub;

  // Supervision of remote setpoints and sense values
  wire spRestart = wrSet | wrPct | wrLim | wrDev | wrMode;
  wire spRun = remoteCtl | bmcPresent_r;
  wire spExpire;
  wire vsExpire;
  wire tsExpire;
  wire hexIdle;
  wire masterTick;

  cnm_timer #(.W(TIMER_W), .LIMIT(SUPERVISE_CNT)) u_spTimer (
    .core_clk(core_clk),
    .rstn(rstn),
    .run(spRun),
    .restart(spRestart),
    .expired(spExpire)
  );

  cnm_timer #(.W(TIMER_W), .LIMIT(SUPERVISE_CNT)) u_vsTimer (
    .core_clk(core_clk),
    .rstn(rstn),
    .run(vsUse_r),
    .restart(wrVs),
    .expired(vsExpire)
  );

  cnm_timer #(.W(TIMER_W), .LIMIT(SUPERVISE_CNT)) u_tsTimer (
    .core_clk(core_clk),
    .rstn(rstn),
    .run(tsUse_r),
    .restart(wrTs),
    .expired(tsExpire)
  );

  cnm_timer #(.W(TIMER_W), .LIMIT(HEXIDLE_CNT)) u_hexTimer (
    .core_clk(core_clk),
    .rstn(rstn),
    .run(hexActive_r),
    .restart(hexFrameSeen),
    .expired(hexIdle)
  );

  cnm_timer #(.W(TIMER_W), .LIMIT(MASTER_CNT)) u_masterTimer (
    .core_clk(core_clk),
    .rstn(rstn),
    .run(instMaster),
    .restart(wrMode),
    .expired(masterTick)
  );

  // Role register: writes win, a stale remote falls back unless a
  // managing controller is present
  assign mode_nxt = wrMode ? accReq.data[MODE_W-1:0] :
                    (spExpire & ~bmcPresent_r) ? NET_MODE_RST :
                    mode_r;

  // Entering managed remote mode forces the present flag on
  assign bmcPresent_nxt = (wrMode & accReq.data[MODE_REM_BMC]) |
                          (wrBmc ? accReq.data[0] : bmcPresent_r);

  // Lost controller is latched until a fresh setpoint or role write arrives
  assign bmcLost_nxt = (spExpire & bmcPresent_r) |
                       (bmcLost_r & ~spRestart);

  // Remote sensing is in use until released or timed out
  assign vsUse_nxt = wrVs ? (accReq.data[15:0] != VSENSE_NONE) :
                     (vsUse_r & ~vsExpire);
  assign tsUse_nxt = wrTs ? (accReq.data[15:0] != TSENSE_NONE) :
                     (tsUse_r & ~tsExpire);
  assign vsense_nxt = wrVs ? accReq.data[15:0] :
                      vsExpire ? VSENSE_NONE : vsense_r;
  assign tsense_nxt = wrTs ? accReq.data[15:0] :
                      tsExpire ? TSENSE_NONE : tsense_r;

  assign hexActive_nxt = hexFrameSeen | (hexActive_r & ~hexIdle);

  // Control source; the group role adds no gathering of its own
  wire [3:0] srcCode = remoteCtl ? SRC_SLAVE :
                       (grpMaster & instMaster) ? SRC_BOTH :
                       instMaster ? SRC_INST :
                       grpMaster ? SRC_GROUP : SRC_ALONE;

  always_comb
  begin
    status_nxt = {4'h0, srcCode};
    status_nxt[STAT_TSENSE_BIT] = tsUse_r;
    status_nxt[STAT_VSENSE_BIT] = vsUse_r;
  end

  // Masters and stand-alone units keep the internal profile
  assign effSet_nxt = voltRemote ? voltSet_r : intSetpoint;

  // Read answer
  wire [31:0] rdData =
    idMode ? {26'h0, mode_r} :
    idStatus ? {24'h0, status_r} :
    idSet ? {16'h0, effSet_r} :
    idVs ? {16'h0, vsense_r} :
    idTs ? {16'h0, tsense_r} :
    idElapsed ? chargeElapsed :
    idAbsorb ? {16'h0, absorbLeft} :
    idDev ? {24'h0, devState_r} :
    idPct ? {24'h0, curPct_r} :
    idLim ? {16'h0, curLim_r} :
    idBmc ? {31'h0, bmcPresent_r} :
    idOutV ? {16'h0, outVoltage} :
    idRtc ? {24'h0, rtcState} : 32'h0;

  always_comb
  begin
    rsp_nxt.valid = accReq.valid;
    rsp_nxt.err = accReq.valid & ~(idWritable | (idReadOnly & ~wr));
    rsp_nxt.data = accReq.valid ? rdData : 32'h0;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_r <= NET_MODE_RST;
      voltSet_r <= VOLT_SET_RST;
      vsense_r <= VSENSE_NONE;
      tsense_r <= TSENSE_NONE;
      vsUse_r <= 1'b0;
      tsUse_r <= 1'b0;
      devState_r <= DEV_STATE_RST;
      curPct_r <= CUR_PCT_RST;
      curLim_r <= CUR_LIMIT_RST;
      bmcPresent_r <= 1'b0;
      bmcLost_r <= 1'b0;
      hexActive_r <= 1'b0;
      status_r <= {4'h0, SRC_ALONE};
      effSet_r <= VOLT_SET_RST;
      rsp_r <= '0;
    end
    else
    begin
      mode_r <= mode_nxt;
      voltSet_r <= wrSet ? accReq.data[15:0] : voltSet_r;
      vsense_r <= vsense_nxt;
      tsense_r <= tsense_nxt;
      vsUse_r <= vsUse_nxt;
      tsUse_r <= tsUse_nxt;
      devState_r <= wrDev ? accReq.data[7:0] : devState_r;
      curPct_r <= wrPct ? accReq.data[7:0] : curPct_r;
      curLim_r <= wrLim ? accReq.data[15:0] : curLim_r;
      bmcPresent_r <= bmcPresent_nxt;
      bmcLost_r <= bmcLost_nxt;
      hexActive_r <= hexActive_nxt;
      status_r <= status_nxt;
      effSet_r <= effSet_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  // Asynchronous report sources
  logic [RPT_NUM-1:0][31:0] srcVal;
  logic [RPT_NUM-1:0] srcChanged;
  logic [RPT_NUM-1:0] pendSet;
  logic [RPT_NUM-1:0] pend_r;
  logic [RPT_NUM-1:0] pend_nxt;

  always_comb
  begin
    srcVal = '0;
    srcVal[RPT_VOLT_SET] = {16'h0, effSet_r};
    srcVal[RPT_ELAPSED] = chargeElapsed;
    srcVal[RPT_ABSORB] = {16'h0, absorbLeft};
    srcVal[RPT_OUT_VOLT] = {16'h0, outVoltage};
    srcVal[RPT_RTC] = {24'h0, rtcState};
    srcVal[RPT_VSENSE] = {16'h0, vsense_r};
    srcVal[RPT_TSENSE] = {16'h0, tsense_r};
    srcVal[RPT_MODE] = {26'h0, mode_r};
    srcVal[RPT_STATUS] = {24'h0, status_r};
  end

  cnm_change_det #(.N(RPT_NUM), .W(32)) u_changeDet (
    .core_clk(core_clk),
    .rstn(rstn),
    .value(srcVal),
    .changed(srcChanged)
  );

  always_comb
  begin
    pendSet = srcChanged & {RPT_NUM{hexActive_r}};
    pendSet[RPT_HIST_TOTAL] = histTotalChanged;
    pendSet[RPT_HIST_TODAY] = histTodayChanged;
    pendSet[RPT_VOLT_SET] = pendSet[RPT_VOLT_SET] | masterTick;
    pendSet[RPT_ELAPSED] = pendSet[RPT_ELAPSED] | masterTick;
    pendSet[RPT_ABSORB] = pendSet[RPT_ABSORB] | masterTick;
    pendSet[RPT_VSENSE] = pendSet[RPT_VSENSE] | vsExpire;
    pendSet[RPT_TSENSE] = pendSet[RPT_TSENSE] | tsExpire;
  end

  // Report engine: one report held until taken, none started while a
  // response frame is on the line
  cnm_rpt_state_e state_r;
  cnm_rpt_state_e state_nxt;
  logic [15:0] rptId_r;
  logic [31:0] rptData_r;

  wire [RPT_NUM-1:0] grant = pend_r & (~pend_r + RPT_NUM'(1));
  wire [RPT_IDX_W-1:0] grantIdx = oneHotIdx(grant);
  wire load = (state_r == RPT_IDLE) & (|pend_r) & ~respBusy;
  wire [RPT_NUM-1:0] served = load ? grant : '0;

  // A change in the cycle its report is taken stays pending
  assign pend_nxt = (pend_r & ~served) | pendSet;

  always_comb
  begin
    case (state_r)
      RPT_IDLE: state_nxt = load ? RPT_HOLD : RPT_IDLE;
      RPT_HOLD: state_nxt = rptReady ? RPT_IDLE : RPT_HOLD;
      default: state_nxt = RPT_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= RPT_IDLE;
      pend_r <= '0;
      rptId_r <= 16'h0000;
      rptData_r <= 32'h0;
    end
    else
    begin
      state_r <= state_nxt;
      pend_r <= pend_nxt;
      rptId_r <= load ? rptIdOf(grantIdx) : rptId_r;
      rptData_r <= load ? srcVal[grantIdx] : rptData_r;
    end
  end

  // Outputs
  assign rpt = {state_r == RPT_HOLD, CMD_ASYNC, rptId_r, ASYNC_FLAGS,
                rptData_r};
  assign accRsp = rsp_r;
  assign netMode = {2'b00, mode_r};
  assign netStatus = status_r;
  assign standAlone = (status_r[3:0] == SRC_ALONE);
  assign setpointRemote = voltRemote;
  assign hubDisplay = remHub;
  assign voltSetpoint = effSet_r;
  assign remoteDevState = devState_r;
  assign curPercent = curPct_r;
  assign curLimit = curLim_r;
  assign bmcPresent = bmcPresent_r;
  assign bmcErrCode = bmcLost_r ? ERR_BMC_LOST : 8'h00;
  assign vsenseUse = vsUse_r;
  assign tsenseUse = tsUse_r;
  assign vsenseVal = vsense_r;
  assign tsenseVal = tsense_r;

endmodule

// file: hdl/cnm_pkg.sv
package cnm_pkg;

  // Register identifiers on the get/set access port; the history ids are only reported
  localparam logic [15:0] ID_NET_MODE = 16'h200e;
  localparam logic [15:0] ID_NET_STATUS = 16'h200f;
  localparam logic [15:0] ID_VOLT_SET = 16'h2001;
  localparam logic [15:0] ID_VSENSE = 16'h2002;
  localparam logic [15:0] ID_TSENSE = 16'h2003;
  localparam logic [15:0] ID_ELAPSED = 16'h2007;
  localparam logic [15:0] ID_ABSORB_LEFT = 16'h2008;
  localparam logic [15:0] ID_DEV_STATE = 16'h0201;
  localparam logic [15:0] ID_CUR_PCT = 16'h2014;
  localparam logic [15:0] ID_CUR_LIMIT = 16'h2015;
  localparam logic [15:0] ID_BMC_PRESENT = 16'hede8;
  localparam logic [15:0] ID_HIST_TOTAL = 16'h104f;
  localparam logic [15:0] ID_HIST_TODAY = 16'h1050;
  localparam logic [15:0] ID_OUT_VOLT = 16'hedd5;
  localparam logic [15:0] ID_RTC_STATE = 16'h2030;

  // Network role flag positions
  localparam int MODE_NETWORKED = 0;
  localparam int MODE_REM_CHARGE = 1;
  localparam int MODE_REM_HUB = 2;
  localparam int MODE_REM_BMC = 3;
  localparam int MODE_GRP_MASTER = 4;
  localparam int MODE_INST_MASTER = 5;
  localparam int MODE_W = 6;

  // Role values used by the controller
  localparam logic [7:0] MODE_STANDALONE = 8'h00;
  localparam logic [7:0] MODE_CHARGE_MASTER = 8'h21;
  localparam logic [7:0] MODE_REMOTE_SLAVE = 8'h03;
  localparam logic [7:0] MODE_REMOTE_HUB = 8'h05;
  localparam logic [7:0] MODE_REMOTE_BMC = 8'h09;

  // Control source codes and sense flags of the feedback register
  localparam logic [3:0] SRC_SLAVE = 4'h0;
  localparam logic [3:0] SRC_GROUP = 4'h1;
  localparam logic [3:0] SRC_INST = 4'h2;
  localparam logic [3:0] SRC_BOTH = 4'h3;
  localparam logic [3:0] SRC_ALONE = 4'h4;
  localparam int STAT_TSENSE_BIT = 6;
  localparam int STAT_VSENSE_BIT = 7;

  localparam logic [7:0] ERR_BMC_LOST = 8'h43;
  localparam logic [3:0] CMD_ASYNC = 4'ha;
  localparam logic [7:0] ASYNC_FLAGS = 8'h00;
  localparam logic [15:0] VSENSE_NONE = 16'hffff;
  localparam logic [15:0] TSENSE_NONE = 16'h7fff;

  // Reset values
  localparam logic [MODE_W-1:0] NET_MODE_RST = 6'h00;
  localparam logic [15:0] VOLT_SET_RST = 16'h0000;
  localparam logic [7:0] DEV_STATE_RST = 8'h00;
  localparam logic [7:0] CUR_PCT_RST = 8'h00;
  localparam logic [15:0] CUR_LIMIT_RST = 16'h0000;

  // Timing
  localparam longint CLK_HZ = 100_000_000;
  localparam longint SUPERVISE_TIME_S = 60;
  localparam longint HEXIDLE_TIME_S = 120;
  localparam longint MASTER_PERIOD_MS = 1000;
  localparam longint SUPERVISE_CYCLES = SUPERVISE_TIME_S * CLK_HZ;
  localparam longint HEXIDLE_CYCLES = HEXIDLE_TIME_S * CLK_HZ;
  localparam longint MASTER_PERIOD_CYCLES = MASTER_PERIOD_MS * CLK_HZ / 1000;
  localparam int TIMER_W = 36;

  // Asynchronous report sources, lowest index served first
  localparam int RPT_HIST_TOTAL = 0;
  localparam int RPT_HIST_TODAY = 1;
  localparam int RPT_VOLT_SET = 2;
  localparam int RPT_ELAPSED = 3;
  localparam int RPT_ABSORB = 4;
  localparam int RPT_OUT_VOLT = 5;
  localparam int RPT_RTC = 6;
  localparam int RPT_VSENSE = 7;
  localparam int RPT_TSENSE = 8;
  localparam int RPT_MODE = 9;
  localparam int RPT_STATUS = 10;
  localparam int RPT_NUM = 11;
  localparam int RPT_IDX_W = 4;

  typedef enum logic [1:0] {
    RPT_IDLE = 2'b00,
    RPT_HOLD = 2'b01
  } cnm_rpt_state_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] id;
    logic [31:0] data;
  } cnm_req_s;

  typedef struct packed {
    logic valid;
    logic err;
    logic [31:0] data;
  } cnm_rsp_s;

  typedef struct packed {
    logic valid;
    logic [3:0] cmd;
    logic [15:0] id;
    logic [7:0] flags;
    logic [31:0] data;
  } cnm_rpt_s;

endpackage

// file: hdl/cnm_timer.sv
`timescale 1ns/100ps
module cnm_timer
  import cnm_pkg::*;
#(
  parameter int W = TIMER_W,
  parameter logic [W-1:0] LIMIT = W'(SUPERVISE_CYCLES)
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic restart,
  output logic expired
);

  localparam logic [W-1:0] LAST = LIMIT - W'(1);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  wire atEnd = (count_r == LAST);

  // Restarts from zero on restart or when stopped; wraps when it expires
  assign expired = run & ~restart & atEnd;
  assign count_nxt = (restart | ~run | atEnd) ? '0 : count_r + W'(1);

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      count_r <= '0;
    else
      count_r <= count_nxt;
  end

endmodule

// file: verif/cnm_link_peer.sv
`timescale 1ns/100ps
module cnm_link_peer
  import cnm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input cnm_rpt_s rpt,
  input wire logic slow,
  output logic rptReady
);
  logic [1:0] stall_r;
  logic [15:0] ids[$];
  logic [31:0] dats[$];

  // Collects reports and takes them through rptReady, every cycle or, when slow, every fourth cycle
  always @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      stall_r <= 2'h0;
      rptReady <= 1'h0;
    end
    else
    begin
      stall_r <= stall_r + 2'h1;
      rptReady <= !slow || stall_r == 2'h3;
      if (rpt.valid && rptReady)
      begin
        ids.push_back(rpt.id);
        dats.push_back(rpt.data);
      end
    end
endmodule

// file: verif/cnm_network_role_sva.sv
`timescale 1ns/100ps
module cnm_network_role_sva
  import cnm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input cnm_req_s accReq,
  input cnm_rsp_s accRsp,
  input wire logic respBusy,
  input cnm_rpt_s rpt,
  input wire logic rptReady,
  input wire logic [7:0] netMode,
  input wire logic [7:0] netStatus,
  input wire logic setpointRemote,
  input wire logic hubDisplay,
  input wire logic bmcPresent,
  input wire logic vsenseUse,
  input wire logic tsenseUse,
  input wire logic [15:0] vsenseVal
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  logic [5:0] reqData_r;
  wire logic wrMode = accReq.valid && accReq.write &&
    accReq.id == ID_NET_MODE;
  wire logic [3:0] srcExp = (|netMode[3:1]) ? SRC_SLAVE :
    (netMode[5] && netMode[4]) ? SRC_BOTH :
    netMode[5] ? SRC_INST : netMode[4] ? SRC_GROUP : SRC_ALONE;

  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      reqData_r <= '0;
    else
      reqData_r <= accReq.data[5:0];

  sequence s_modeWr;
    wrMode ##1 accRsp.valid;
  endsequence

  property p_answer;
    accReq.valid |=> accRsp.valid;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_modeFlags;
    s_modeWr |-> netMode == {2'h0, reqData_r};
  endproperty
  a_modeFlags: assert property (p_modeFlags) else $error("mode");
  property p_source;
    $stable(netMode) |-> netStatus[3:0] == srcExp;
  endproperty
  a_source: assert property (p_source) else $error("source");
  property p_sense;
    $stable(vsenseUse) && $stable(tsenseUse) |->
      netStatus[7:6] == {vsenseUse, tsenseUse};
  endproperty
  a_sense: assert property (p_sense) else $error("sense bits");
  property p_remote;
    setpointRemote == (netMode[1] | netMode[2]) && hubDisplay == netMode[2];
  endproperty
  a_remote: assert property (p_remote) else $error("remote");
  property p_bmcSet;
    wrMode && accReq.data[3] |=> bmcPresent;
  endproperty
  a_bmcSet: assert property (p_bmcSet) else $error("bmc set");
  property p_noFall;
    bmcPresent && netMode[3] && !accReq.valid |=> netMode[3];
  endproperty
  a_noFall: assert property (p_noFall) else $error("fallback");
  property p_rptForm;
    rpt.valid |-> rpt.cmd == CMD_ASYNC && rpt.flags == ASYNC_FLAGS;
  endproperty
  a_rptForm: assert property (p_rptForm) else $error("format");
  property p_rptHold;
    rpt.valid && !rptReady |=>
      rpt.valid && $stable(rpt.id) && $stable(rpt.data);
  endproperty
  a_rptHold: assert property (p_rptHold) else $error("hold");
  property p_rptWait;
    $rose(rpt.valid) |-> !$past(respBusy);
  endproperty
  a_rptWait: assert property (p_rptWait) else $error("busy");
  property p_rptDone;
    rpt.valid && rptReady |=> !rpt.valid;
  endproperty
  a_rptDone: assert property (p_rptDone) else $error("done");
  property p_vNone;
    !vsenseUse |-> vsenseVal == VSENSE_NONE;
  endproperty
  a_vNone: assert property (p_vNone) else $error("vsense");
endmodule

bind cnm_network_role cnm_network_role_sva u_sva (
  .core_clk, .rstn, .accReq, .accRsp, .respBusy, .rpt, .rptReady,
  .netMode, .netStatus, .setpointRemote, .hubDisplay, .bmcPresent,
  .vsenseUse, .tsenseUse, .vsenseVal
);

// file: verif/cnm_network_role_tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, sn) \
  begin \
    check_count++; \
    if ((sn) !== (ex)) \
    begin \
      failures++; \
      $display("mismatch %s exp %0h got %0h", nm, ex, sn); \
    end \
  end
module cnm_network_role_tb;
  import cnm_pkg::*;
  localparam int SUP = 50;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  cnm_req_s accReq = '0;
  cnm_rsp_s accRsp;
  cnm_rpt_s rpt;
  logic respBusy = 1'h0, hexFrameSeen = 1'h0, slow = 1'h0;
  logic histTotalChanged = 1'h0, histTodayChanged = 1'h0;
  logic [15:0] intSetpoint = 16'h0123, absorbLeft = 16'h0045;
  logic [15:0] outVoltage = 16'h0678, voltSetpoint, curLimit;
  logic [15:0] vsenseVal, tsenseVal;
  logic [31:0] chargeElapsed = 32'h00000abc, q;
  logic [7:0] rtcState = 8'h01, netMode, netStatus, remoteDevState;
  logic [7:0] curPercent, bmcErrCode;
  logic rptReady, standAlone, setpointRemote, hubDisplay, bmcPresent;
  logic vsenseUse, tsenseUse;
  int failures = 0, check_count = 0, cyc = 0, m;
  int modes[8] = '{8'h00, 8'h21, 8'h03, 8'h05, 8'h09, 8'h10, 8'h30, 8'hff};

  always #5 core_clk = ~core_clk;

  cnm_network_role #(.SUPERVISE_CNT(TIMER_W'(SUP)),
    .HEXIDLE_CNT(TIMER_W'(80)), .MASTER_CNT(TIMER_W'(20))) dut (
    .core_clk, .rstn, .accReq, .accRsp, .respBusy, .hexFrameSeen,
    .intSetpoint, .chargeElapsed, .absorbLeft, .outVoltage, .rtcState,
    .histTotalChanged, .histTodayChanged, .rpt, .rptReady, .netMode,
    .netStatus, .standAlone, .setpointRemote, .hubDisplay, .voltSetpoint,
    .remoteDevState, .curPercent, .curLimit, .bmcPresent, .bmcErrCode,
    .vsenseUse, .tsenseUse, .vsenseVal, .tsenseVal);
  cnm_link_peer peer (.core_clk, .rstn, .rpt, .slow, .rptReady);

  function automatic int expSt(int md, int t, int v);
    int s;
    s = ((md >> 5) & 1) * 2 + ((md >> 4) & 1);
    if (s == 0)
      s = 4;
    if ((md & 14) != 0)
      s = 0;
    return s | (t << 6) | (v << 7);
  endfunction

  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic acc(input logic wr, input logic [15:0] id,
    input logic [31:0] d, input logic ex);
    @(posedge core_clk);
    accReq <= '{1'h1, wr, id, d};
    @(posedge core_clk);
    accReq <= '0;
    #1;
    `CHK("rsp_valid", 1'h1, accRsp.valid)
    `CHK("rsp_err", ex, accRsp.err)
    q = accRsp.data;
  endtask

  task automatic flush();
    peer.ids.delete();
    peer.dats.delete();
  endtask

  // Waits for the next report the peer took and compares it
  task automatic expRpt(input int id, input int d);
    int n;
    logic [15:0] i;
    logic [31:0] x;
    n = 0;
    while (peer.ids.size() == 0 && n < 200)
    begin
      @(posedge core_clk);
      n++;
    end
    #1;
    `CHK("rpt_seen", 1'h1, peer.ids.size() != 0)
    if (peer.ids.size() != 0)
    begin
      i = peer.ids.pop_front();
      x = peer.dats.pop_front();
      `CHK("rpt_id", id, i)
      `CHK("rpt_data", d, x)
    end
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      failures++;
      wrap_up();
    end
  end

  initial
  begin
    void'($urandom(32'h7a54ca82));
    repeat (6) @(posedge core_clk);
    rstn <= 1'h1;
    #1;
    `CHK("rst_mode", 8'h00, netMode)
    `CHK("rst_status", 8'h04, netStatus)
    `CHK("rst_vnone", VSENSE_NONE, vsenseVal)
    `CHK("rst_tnone", TSENSE_NONE, tsenseVal)
    foreach (modes[i])
    begin
      m = (i == 7) ? ($urandom & 8'hff) : modes[i];
      acc(1'h1, ID_NET_MODE, m, 1'h0);
      tick(2);
      `CHK("mode", m & 8'h3f, netMode)
      `CHK("status", expSt(m, 0, 0), netStatus)
      `CHK("alone", expSt(m, 0, 0) == 4, standAlone)
      `CHK("remote", m[1] | m[2], setpointRemote)
      `CHK("hub", m[2], hubDisplay)
      `CHK("bmc", m[3], bmcPresent)
      acc(1'h1, ID_BMC_PRESENT, 0, 1'h0);
    end
    acc(1'h1, ID_NET_STATUS, 0, 1'h1);
    acc(1'h1, ID_ELAPSED, 0, 1'h1);
    acc(1'h0, 16'h1234, 0, 1'h1);
    acc(1'h0, ID_NET_STATUS, 0, 1'h0);
    `CHK("status_rd", expSt(m, 0, 0), q)
    acc(1'h1, ID_NET_MODE, 8'h03, 1'h0);
    acc(1'h1, ID_DEV_STATE, 32'h05, 1'h0);
    `CHK("devstate", 8'h05, remoteDevState)
    repeat (2)
    begin
      tick(30);
      acc(1'h1, ID_VOLT_SET, 32'h0555, 1'h0);
    end
    tick(SUP - 6);
    `CHK("slave_kept", 8'h03, netMode)
    `CHK("setpoint", 16'h0555, voltSetpoint)
    tick(10);
    `CHK("fallback", 8'h00, netMode)
    `CHK("alone_again", 1'h1, standAlone)
    acc(1'h1, ID_NET_MODE, 8'h09, 1'h0);
    acc(1'h1, ID_CUR_PCT, 32'h32, 1'h0);
    `CHK("pct", 8'h32, curPercent)
    tick(SUP + 4);
    `CHK("bmc_kept", 8'h09, netMode)
    `CHK("bmc_err", ERR_BMC_LOST, bmcErrCode)
    acc(1'h1, ID_CUR_LIMIT, 32'h64, 1'h0);
    `CHK("limit", 16'h0064, curLimit)
    `CHK("err_clr", 8'h00, bmcErrCode)
    acc(1'h1, ID_NET_MODE, 0, 1'h0);
    acc(1'h1, ID_BMC_PRESENT, 0, 1'h0);
    slow <= 1'h1;
    acc(1'h1, ID_VSENSE, 32'h0500, 1'h0);
    acc(1'h1, ID_TSENSE, 32'h0200, 1'h0);
    tick(2);
    `CHK("vuse", 1'h1, vsenseUse)
    `CHK("sense_stat", expSt(0, 1, 1), netStatus)
    flush();
    tick(SUP + 3);
    `CHK("vto", VSENSE_NONE, vsenseVal)
    `CHK("tto", TSENSE_NONE, tsenseVal)
    expRpt(ID_VSENSE, VSENSE_NONE);
    expRpt(ID_TSENSE, TSENSE_NONE);
    flush();
    @(posedge core_clk);
    respBusy <= 1'h1;
    histTotalChanged <= 1'h1;
    histTodayChanged <= 1'h1;
    @(posedge core_clk);
    histTotalChanged <= 1'h0;
    histTodayChanged <= 1'h0;
    tick(6);
    `CHK("busy_hold", 1'h0, rpt.valid)
    @(posedge core_clk);
    respBusy <= 1'h0;
    expRpt(ID_HIST_TOTAL, 0);
    expRpt(ID_HIST_TODAY, 0);
    @(posedge core_clk);
    hexFrameSeen <= 1'h1;
    @(posedge core_clk);
    hexFrameSeen <= 1'h0;
    tick(2);
    flush();
    m = ($urandom & 32'hfffe) | 1;
    @(posedge core_clk);
    outVoltage <= m[15:0];
    rtcState <= 8'h03;
    expRpt(ID_OUT_VOLT, m & 32'hffff);
    expRpt(ID_RTC_STATE, 8'h03);
    tick(90);
    flush();
    @(posedge core_clk);
    outVoltage <= 16'h0002;
    tick(20);
    `CHK("hex_quiet", 0, peer.ids.size())
    acc(1'h1, ID_NET_MODE, 8'h21, 1'h0);
    flush();
    expRpt(ID_VOLT_SET, 16'h0123);
    expRpt(ID_ELAPSED, 32'h00000abc);
    expRpt(ID_ABSORB_LEFT, 16'h0045);
    `CHK("master_stat", 8'h02, netStatus)
    `CHK("own_profile", 16'h0123, voltSetpoint)
    wrap_up();
  end
endmodule
